// ==== hw/r14d_core.sv ====
// Purpose: decode and execute of a 14-bit instruction word core
// Assumes: instr_i is the word at pc_o, same clock, valid any time
// Notes: clk_i is the oscillator; one instruction per four clocks
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "r14d_map.svh"
`default_nettype none
module r14d_core (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [13:0] instr_i,
    input wire logic [5:0] pin_i,
    input wire r14d_pkg::r14d_apb_req_t apb_i,
    output var r14d_pkg::r14d_apb_rsp_t apb_o,
    output logic [12:0] pc_o,
    output logic [5:0] port_o,
    output logic [5:0] pin_direction_register_o
);
    import r14d_pkg::*;

    r14d_state_t st;
    r14d_state_t n;
    logic [1:0] rst_q;
    logic rst_n;
    logic tick;
    logic exec;
    logic [6:0] fa;
    logic [2:0] bsel;
    logic [7:0] k;
    logic [7:0] src;
    logic [7:0] res;
    logic [9:0] sum;
    logic wr_f;
    logic wr_w;
    logic f_c;
    logic f_dc;
    logic f_z;
    logic nc;
    logic ndc;
    logic skip;
    logic push;
    logic pop;
    logic [2:0] spm;

    // Add with carry in; returns {carry, digit carry, sum}
    function automatic logic [9:0] alu_add(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic ci);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction

    // APB register select: 0 none, 1 control, 2 core view
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        if (a == `R14D_O_CTRL) begin
            return 2'h1;
        end else if (a == `R14D_O_CORE) begin
            return 2'h2;
        end
        return 2'h0;
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    always_comb begin
        n = st;
        tick = (st.ph == 2'(`R14D_OSC_PER_CYC - 1));
        n.ph = st.ph + 2'h1;
        exec = tick & st.ctrl[`R14D_C_RUN] & ~st.flush;
        // Pins cross in through two flops
        n.pin_a = pin_i;
        n.pin_b = st.pin_a;
        fa = instr_i[6:0];
        bsel = instr_i[9:7];
        k = instr_i[7:0];
        spm = st.sp - 3'h1;
        case (fa)
            `R14D_A_TIMER: src = st.timer;
            `R14D_A_PCL: src = st.pc[7:0];
            `R14D_A_STATUS: src = st.status;
            `R14D_A_PIN_DIRECTION_REGISTER: src = {2'h3, st.pin_direction_register} | 8'h08;
            `R14D_A_PORT: src = {2'h0, st.pin_b};
            `R14D_A_PC_HIGH_HOLDING_LATCH: src = {3'h0, st.pc_high_holding_latch};
            `R14D_A_INTCON: src = {st.global_irq_enable, 7'h00};
            default: src = st.mem[fa];
        endcase
        res = 8'h00;
        sum = 10'h000;
        wr_f = 1'b0;
        wr_w = 1'b0;
        f_c = 1'b0;
        f_dc = 1'b0;
        f_z = 1'b0;
        nc = st.status[`R14D_B_C];
        ndc = 1'b0;
        skip = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        // Timer steps each cycle, or on prescaler wrap when assigned
        if (tick) begin
            n.presc = st.presc + 8'h01;
            if (!st.ctrl[`R14D_C_PSA] || st.presc == 8'hFF) begin
                n.timer = st.timer + 8'h01;
            end
            n.flush = 1'b0;
        end
        if (exec) begin
            n.pc = st.pc + 13'h0001;
            unique case (instr_i[13:12])
                2'b00: begin
                    if (instr_i[11:7] == 5'h00) begin
                        unique case (instr_i[6:0])
                            7'h08: pop = 1'b1;
                            7'h09: begin
                                pop = 1'b1;
                                n.global_irq_enable = 1'b1;
                            end
                            7'h63: begin
                                n.status[`R14D_B_TO] = 1'b1;
                                n.status[`R14D_B_PD] = 1'b0;
                            end
                            7'h64: begin
                                n.status[`R14D_B_TO] = 1'b1;
                                n.status[`R14D_B_PD] = 1'b1;
                            end
                            default: res = 8'h00;
                        endcase
                    end else begin
                        wr_f = instr_i[7];
                        wr_w = ~instr_i[7];
                        unique case (r14d_bop_t'(instr_i[11:8]))
                            BOP_STORE: res = st.w;
                            BOP_CLEAR: f_z = 1'b1;
                            BOP_SUB: begin
                                sum = alu_add(src, ~st.w, 1'b1);
                                f_c = 1'b1;
                                f_dc = 1'b1;
                                f_z = 1'b1;
                            end
                            BOP_ADD: begin
                                sum = alu_add(src, st.w, 1'b0);
                                f_c = 1'b1;
                                f_dc = 1'b1;
                                f_z = 1'b1;
                            end
                            BOP_DEC: res = src - 8'h01;
                            BOP_OR: res = src | st.w;
                            BOP_AND: res = src & st.w;
                            BOP_XOR: res = src ^ st.w;
                            BOP_MOVE: res = src;
                            BOP_COMP: res = ~src;
                            BOP_INC: res = src + 8'h01;
                            BOP_DECSZ: begin
                                res = src - 8'h01;
                                skip = (res == 8'h00);
                            end
                            BOP_INCSZ: begin
                                res = src + 8'h01;
                                skip = (res == 8'h00);
                            end
                            BOP_RRC: begin
                                res = {st.status[`R14D_B_C], src[7:1]};
                                nc = src[0];
                                f_c = 1'b1;
                            end
                            BOP_RLC: begin
                                res = {src[6:0], st.status[`R14D_B_C]};
                                nc = src[7];
                                f_c = 1'b1;
                            end
                            BOP_SWAP: res = {src[3:0], src[7:4]};
                        endcase
                        if (instr_i[11:8] inside {4'h3, 4'h4, 4'h5,
                            4'h6, 4'h8, 4'h9, 4'hA}) begin
                            f_z = 1'b1;
                        end
                    end
                end
                2'b01: begin
                    // read whole byte, change or test one bit
                    unique case (instr_i[11:10])
                        2'b00: begin
                            res = src & ~(8'h01 << bsel);
                            wr_f = 1'b1;
                        end
                        2'b01: begin
                            res = src | (8'h01 << bsel);
                            wr_f = 1'b1;
                        end
                        2'b10: skip = ~src[bsel];
                        2'b11: skip = src[bsel];
                    endcase
                end
                2'b10: begin
                    push = ~instr_i[11];
                    n.pc = {st.pc_high_holding_latch[4:3], instr_i[10:0]};
                    n.flush = 1'b1;
                end
                2'b11: begin
                    wr_w = 1'b1;
                    unique casez (instr_i[11:8])
                        4'b00??: res = k;
                        4'b01??: begin
                            res = k;
                            pop = 1'b1;
                        end
                        4'b1000: res = k | st.w;
                        4'b1001: res = k & st.w;
                        4'b1010: res = k ^ st.w;
                        4'b1011: wr_w = 1'b0;
                        4'b110?: sum = alu_add(k, ~st.w, 1'b1);
                        4'b111?: sum = alu_add(k, st.w, 1'b0);
                    endcase
                    f_z = (instr_i[11:10] == 2'b10) & (instr_i[9:8] != 2'b11);
                    if (instr_i[11:10] == 2'b11) begin
                        f_c = 1'b1;
                        f_dc = 1'b1;
                        f_z = 1'b1;
                    end
                end
            endcase
            if (f_dc) begin
                res = sum[7:0];
                nc = sum[9];
                ndc = sum[8];
            end
            if (wr_w) begin
                n.w = res;
            end
            if (wr_f) begin
                case (fa)
                    `R14D_A_TIMER: begin
                        n.timer = res;
                        if (st.ctrl[`R14D_C_PSA]) begin
                            n.presc = 8'h00;
                        end
                    end
                    `R14D_A_PCL: begin
                        n.pc = {st.pc_high_holding_latch, res};
                        n.flush = 1'b1;
                    end
                    `R14D_A_STATUS: n.status = res;
                    `R14D_A_PIN_DIRECTION_REGISTER: n.pin_direction_register = res[5:0] | 6'h08;
                    `R14D_A_PORT: n.port = res[5:0];
                    `R14D_A_PC_HIGH_HOLDING_LATCH: n.pc_high_holding_latch = res[4:0];
                    `R14D_A_INTCON: n.global_irq_enable = res[`R14D_B_GIE];
                    default: n.mem[fa] = res;
                endcase
            end
            // produced flags win over written ones
            if (f_c) begin
                n.status[`R14D_B_C] = nc;
            end
            if (f_dc) begin
                n.status[`R14D_B_DC] = ndc;
            end
            if (f_z) begin
                n.status[`R14D_B_Z] = (res == 8'h00);
            end
            // Stack: returns reload the whole PC
            if (push) begin
                n.stack[st.sp] = st.pc + 13'h0001;
                n.sp = st.sp + 3'h1;
            end
            if (pop) begin
                n.sp = spm;
                n.pc = st.stack[spm];
                n.flush = 1'b1;
            end
            // skip jumps over next word, dead cycle
            if (skip) begin
                n.pc = st.pc + 13'h0002;
                n.flush = 1'b1;
            end
        end
        // APB: answer is set up in the setup cycle, ready in access
        n.rsp.pready = 1'b0;
        n.rsp.pslverr = 1'b0;
        if (apb_i.psel && !apb_i.penable) begin
            n.rsp.pready = 1'b1;
            unique case (reg_sel(apb_i.paddr))
                2'h1: n.rsp.prdata = {30'h0, st.ctrl};
                2'h2: n.rsp.prdata = {3'h0, st.pc, st.status, st.w};
                default: begin
                    n.rsp.prdata = 32'h0;
                    n.rsp.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_i.psel && apb_i.penable && st.rsp.pready &&
            apb_i.pwrite && reg_sel(apb_i.paddr) == 2'h1) begin
            n.ctrl = apb_i.pwdata[1:0];
        end
    end

    // State register; only constants under reset
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.status <= `R14D_RST_STATUS;
            st.pin_direction_register <= `R14D_RST_PIN_DIRECTION_REGISTER;
        end else begin
            st <= n;
        end
    end

    assign apb_o = st.rsp;
    assign pc_o = st.pc;
    assign port_o = st.port;
    assign pin_direction_register_o = st.pin_direction_register;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_gap;
        !tick [*3] ##1 tick;
    endsequence
    a_cycle_len: assert property (tick |=> s_gap)
        else $error("instruction cycle not four clocks");
    a_status_override: assert property (
        exec && instr_i[13:7] == 7'h03 && fa == `R14D_A_STATUS
        |=> st.status == 8'h04)
        else $error("cleared flag register is not 04");
    a_pin_direction_register_input_bit: assert property (
        pin_direction_register_o[`R14D_B_INPIN]) else $error("direction bit 3 not one");
    a_pcl_write_latch: assert property (
        exec && wr_f && fa == `R14D_A_PCL
        |=> st.pc == {$past(st.pc_high_holding_latch), $past(res)} && st.flush)
        else $error("low PC write did not load latch");
    a_jump_target: assert property (
        exec && instr_i[13:12] == 2'b10
        |=> st.pc[10:0] == $past(instr_i[10:0]) && st.flush)
        else $error("jump target not loaded");
    a_dead_cycle: assert property (
        tick && st.flush |=> $stable(st.w) && $stable(st.pc) ##3 !st.flush)
        else $error("dead cycle changed state");
    a_skip_two: assert property (
        exec && skip |=> st.pc == $past(st.pc) + 13'h0002)
        else $error("skip did not pass next word");
    a_timer_presc: assert property (
        exec && wr_f && fa == `R14D_A_TIMER && st.ctrl[`R14D_C_PSA]
        |=> st.presc == 8'h00) else $error("prescaler not cleared");
    a_standby_flags: assert property (
        exec && instr_i == 14'h0063 |=> st.status[4:3] == 2'b10)
        else $error("standby flags wrong");
endmodule
`default_nettype wire

// ==== hw/r14d_map.svh ====
// Purpose: addresses, bit positions, reset values and timing of the core
// Assumes: included by its bare name from core and bench
// Notes: definitions only
`ifndef R14D_MAP_SVH
`define R14D_MAP_SVH
// File addresses of the special registers
`define R14D_A_TIMER 7'h01
`define R14D_A_PCL 7'h02
`define R14D_A_STATUS 7'h03
`define R14D_A_PIN_DIRECTION_REGISTER 7'h05
`define R14D_A_PORT 7'h06
`define R14D_A_PC_HIGH_HOLDING_LATCH 7'h0A
`define R14D_A_INTCON 7'h0B
// Bit positions in the flag register, INTCON and the direction register
`define R14D_B_C 0
`define R14D_B_DC 1
`define R14D_B_Z 2
`define R14D_B_PD 3
`define R14D_B_TO 4
`define R14D_B_GIE 7
`define R14D_B_INPIN 3
// Reset values
`define R14D_RST_STATUS 8'h18
`define R14D_RST_PIN_DIRECTION_REGISTER 6'h3F
// Oscillator periods per instruction cycle
`define R14D_OSC_PER_CYC 4
// APB byte offsets and control bits
`define R14D_O_CTRL 12'h000
`define R14D_O_CORE 12'h004
`define R14D_C_RUN 0
`define R14D_C_PSA 1
`endif

// ==== hw/r14d_pkg.sv ====
// Purpose: types shared by the decode core and its bench
// Assumes: constants come from r14d_map.svh
// Notes: state is one packed struct
`default_nettype none
package r14d_pkg;
    // Byte-oriented operation codes
    typedef enum logic [3:0] {
        BOP_STORE = 4'h0, BOP_CLEAR = 4'h1, BOP_SUB = 4'h2,
        BOP_DEC = 4'h3, BOP_OR = 4'h4, BOP_AND = 4'h5,
        BOP_XOR = 4'h6, BOP_ADD = 4'h7, BOP_MOVE = 4'h8,
        BOP_COMP = 4'h9, BOP_INC = 4'hA, BOP_DECSZ = 4'hB,
        BOP_RRC = 4'hC, BOP_RLC = 4'hD, BOP_SWAP = 4'hE,
        BOP_INCSZ = 4'hF
    } r14d_bop_t;

    // APB request and answer carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } r14d_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } r14d_apb_rsp_t;

    // Whole core state
    typedef struct packed {
        logic [1:0] ph;
        logic flush;
        logic [12:0] pc;
        logic [7:0] w;
        logic [7:0] status;
        logic [4:0] pc_high_holding_latch;
        logic [5:0] pin_direction_register;
        logic [5:0] port;
        logic [7:0] timer;
        logic [7:0] presc;
        logic global_irq_enable;
        logic [1:0] ctrl;
        logic [5:0] pin_a;
        logic [5:0] pin_b;
        logic [2:0] sp;
        logic [7:0][12:0] stack;
        logic [127:0][7:0] mem;
        r14d_apb_rsp_t rsp;
    } r14d_state_t;
endpackage
`default_nettype wire

// ==== tb/r14d_prog_mem.sv ====
// Purpose: program memory model feeding 14-bit words to the core
// Assumes: asynchronous read of the word at the current PC
// Notes: blank words hold the no-op code
`default_nettype none
module r14d_prog_mem (
    input wire logic [12:0] pc_i,
    output logic [13:0] instr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] mem [0:8191];

    // Word follows PC at once; the core samples it at its own tick
    assign instr_o = mem[pc_i];

    // Blank the store so code left by an earlier program never runs
    task automatic wipe();
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 14'h0000;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the decode core
// Assumes: each program ends in a jump to itself
// Notes: results are read back through the CORE word
`include "r14d_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import r14d_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] pin = 6'h00;
    r14d_apb_req_t req = '0;
    r14d_apb_rsp_t rsp;
    logic [12:0] pc;
    logic [13:0] instr;
    logic [5:0] port;
    logic [5:0] pin_direction_register;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int n_compared = 0;

    r14d_core uut (.clk_i(clk), .arst_n_i(arst_n), .instr_i(instr),
        .pin_i(pin), .apb_i(req), .apb_o(rsp), .pc_o(pc),
        .port_o(port), .pin_direction_register_o(pin_direction_register));
    r14d_prog_mem pm (.pc_i(pc), .instr_o(instr));

    always #5 clk = ~clk;

    // Instruction encoders
    function automatic logic [13:0] lit(logic [3:0] c, logic [7:0] k);
        return {2'b11, c, k};
    endfunction
    function automatic logic [13:0] byt(logic [3:0] o, logic d,
                                        logic [6:0] f);
        return {2'b00, o, d, f};
    endfunction
    function automatic logic [13:0] bitw(logic [1:0] s, logic [2:0] b,
                                         logic [6:0] f);
        return {2'b01, s, b, f};
    endfunction
    function automatic logic [13:0] ctl(logic j, logic [10:0] k);
        return {2'b10, j, k};
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n >= 50) begin
            check("pready", 32'h00000001, 32'h00000000);
        end
    endtask

    task automatic reset_dut(input int n);
        arst_n <= 1'b0;
        repeat (n) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // Fresh start: core back at address zero, store blanked
    task automatic fresh();
        reset_dut(2);
        pm.wipe();
    endtask

    // Run until the closing self-jump, then read PC, flags and W
    task automatic run_check(input logic [12:0] stop, input logic [7:0] fl,
                             input logic [7:0] w,
                             input logic [31:0] mode = 32'h00000001);
        int n;
        n = 0;
        apb(1'b1, `R14D_O_CTRL, mode);
        while (pc !== stop && n < 500) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        apb(1'b0, `R14D_O_CORE, 32'h00000000);
        check("pc", {19'h0, stop}, {19'h0, rd[28:16]});
        check("flags", {24'h0, fl}, {24'h0, rd[15:8]});
        check("w", {24'h0, w}, {24'h0, rd[7:0]});
    endtask

    task automatic t_reset();
        check("pin_direction_register", 32'h0000003F, {26'h0, pin_direction_register});
        apb(1'b0, 12'h008, 32'h00000000);
        check("slverr", 32'h00000001, {31'h0, err});
        check("rdata", 32'h00000000, rd);
        apb(1'b0, `R14D_O_CORE, 32'h00000000);
        check("core", 32'h00001800, rd);
    endtask

    // Plain step and the jump word hold four clocks; the jump target
    // holds eight, as the dead cycle keeps it on the bus
    task automatic t_timing();
        int n;
        int m;
        int at[3] = '{1, 2, 4};
        int hold[3] = '{4, 4, 8};
        fresh();
        pm.mem[2] = ctl(1'b1, 11'h004);
        pm.mem[5] = ctl(1'b1, 11'h005);
        apb(1'b1, `R14D_O_CTRL, 32'h00000001);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            m = 1;
            while (pc !== 13'(at[i]) && n < 100) begin
                @(posedge clk);
                n++;
            end
            do begin
                @(posedge clk);
                m++;
            end while (pc === 13'(at[i]) && m < 20);
            check("hold", hold[i], m - 1);
        end
    endtask

    // Prescaler assigned to the timer; a timer write restarts it
    task automatic t_timer();
        fresh();
        pm.mem[0] = lit(4'h0, 8'h40);
        pm.mem[1] = byt(BOP_STORE, 1'b1, `R14D_A_TIMER);
        pm.mem[2] = byt(BOP_MOVE, 1'b0, `R14D_A_TIMER);
        pm.mem[3] = ctl(1'b1, 11'h003);
        run_check(13'h0003, 8'h18, 8'h40, 32'h00000003);
    endtask

    task automatic t_sub();
        fresh();
        pm.mem[0] = lit(4'h0, 8'h05);
        pm.mem[1] = lit(4'hC, 8'h07);
        pm.mem[2] = ctl(1'b1, 11'h002);
        run_check(13'h0002, 8'h1B, 8'h02);
    endtask

    task automatic t_flagreg();
        fresh();
        pm.mem[0] = byt(BOP_CLEAR, 1'b1, `R14D_A_STATUS);
        pm.mem[1] = 14'h0063;
        pm.mem[2] = ctl(1'b1, 11'h002);
        run_check(13'h0002, 8'h14, 8'h00);
    endtask

    task automatic t_rotate();
        fresh();
        pm.mem[0] = lit(4'h0, 8'h81);
        pm.mem[1] = byt(BOP_STORE, 1'b1, 7'h20);
        pm.mem[2] = bitw(2'b01, 3'h6, 7'h20);
        pm.mem[3] = byt(BOP_RLC, 1'b0, 7'h20);
        pm.mem[4] = ctl(1'b1, 11'h004);
        run_check(13'h0004, 8'h19, 8'h82);
    endtask

    // Taken skips would leave xor-with-FF out of W
    task automatic t_skip();
        fresh();
        pm.mem[0] = lit(4'h0, 8'h01);
        pm.mem[1] = byt(BOP_STORE, 1'b1, 7'h21);
        pm.mem[2] = byt(BOP_DECSZ, 1'b1, 7'h21);
        pm.mem[3] = lit(4'hA, 8'hFF);
        pm.mem[4] = bitw(2'b11, 3'h0, 7'h21);
        pm.mem[5] = lit(4'hA, 8'h0F);
        pm.mem[6] = bitw(2'b10, 3'h0, 7'h21);
        pm.mem[7] = lit(4'hA, 8'hFF);
        pm.mem[8] = ctl(1'b1, 11'h008);
        run_check(13'h0008, 8'h18, 8'h0E);
    endtask

    task automatic t_calls();
        fresh();
        pm.mem[0] = ctl(1'b0, 11'h004);
        pm.mem[1] = ctl(1'b0, 11'h006);
        pm.mem[2] = ctl(1'b1, 11'h002);
        pm.mem[4] = lit(4'h4, 8'h3C);
        pm.mem[6] = 14'h0008;
        run_check(13'h0002, 8'h18, 8'h3C);
    endtask

    task automatic t_pclow();
        fresh();
        pm.mem[0] = lit(4'h0, 8'h01);
        pm.mem[1] = byt(BOP_STORE, 1'b1, `R14D_A_PC_HIGH_HOLDING_LATCH);
        pm.mem[2] = lit(4'h0, 8'h10);
        pm.mem[3] = byt(BOP_STORE, 1'b1, `R14D_A_PCL);
        pm.mem[13'h110] = ctl(1'b1, 11'h110);
        run_check(13'h0110, 8'h18, 8'h10);
    endtask

    // Port written back from pins; direction bit 3 survives a clear
    task automatic t_port();
        fresh();
        pin <= 6'h15;
        pm.mem[0] = byt(BOP_CLEAR, 1'b1, `R14D_A_PIN_DIRECTION_REGISTER);
        pm.mem[1] = lit(4'h0, 8'h3F);
        pm.mem[2] = byt(BOP_STORE, 1'b1, `R14D_A_PORT);
        pm.mem[3] = byt(BOP_MOVE, 1'b1, `R14D_A_PORT);
        pm.mem[4] = byt(BOP_MOVE, 1'b0, `R14D_A_PIN_DIRECTION_REGISTER);
        pm.mem[5] = ctl(1'b1, 11'h005);
        run_check(13'h0005, 8'h18, 8'hC8);
        check("port", 32'h00000015, {26'h0, port});
        check("pin_direction_register", 32'h00000008, {26'h0, pin_direction_register});
    endtask

    initial begin
        reset_dut(6);
        t_reset();
        t_timing();
        t_sub();
        t_flagreg();
        t_rotate();
        t_skip();
        t_calls();
        t_pclow();
        t_port();
        t_timer();
        complete_run();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (30000) @(posedge clk);
        check("finish", 32'h00000001, 32'h00000000);
        complete_run();
    end
endmodule
`default_nettype wire
